//--- bench/smbx_bus_model.sv
// Purpose: Other bus master sending one byte frames
// Assumes: Pulled-up wires, 320 ns bit clock
// Notes: SCL stands high between frames
`timescale 1ns/1ps
`default_nettype none
module smbx_bus_model (
  input wire logic go,
  input wire logic [15:0] stretch,
  input wire logic scl_oe_n,
  output logic busy,
  output wire logic scl,
  output wire logic sda
);
  logic scl_m;
  logic sda_m;
  assign scl = scl_m & scl_oe_n;
  assign sda = sda_m;
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge go);
      #10;
      busy = 1'b1;
      sda_m = 1'b0;
      #160;
      for (int i = 0; i < 9; i++) begin
        scl_m = 1'b0;
        if (i == 0) #(stretch * 40);
        #80;
        sda_m = (i == 8) ? 1'b0 : i[0];
        #80;
        scl_m = 1'b1;
        wait (scl === 1'b1);
        #160;
      end
      scl_m = 1'b0;
      sda_m = 1'b0;
      #160;
      scl_m = 1'b1;
      wait (scl === 1'b1);
      #160;
      sda_m = 1'b1;
      #160;
      busy = 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- bench/smbx_top_monitor.sv
// Purpose: Port checker for the bus extension block
// Assumes: Single pclk domain, async active-low reset
// Notes: Tracks control and mask writes locally
`timescale 1ns/1ps
`default_nettype none
module smbx_top_monitor
  import smbx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic master_mode,
  input wire logic slave_arb_lost,
  input wire logic alert_seen,
  input wire logic suspend_in,
  input wire logic suspend_out,
  input wire logic alert_output,
  input wire logic irq
);
  logic [11:0] ctrl_m;
  logic [11:0] mask_m;
  logic wr_c;
  logic wr_m;
  assign wr_c = psel && penable && pwrite && paddr == SMBX_CTRL_OFF;
  assign wr_m = psel && penable && pwrite && paddr == SMBX_MASK_OFF;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_m <= '0;
      mask_m <= '0;
    end else begin
      if (wr_c) ctrl_m <= pwdata[11:0];
      if (wr_m) mask_m <= pwdata[11:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (psel |-> pready) else $error("pready low");
  a_alert_low: assert property (wr_c && pwdata[9] |-> ##[1:3] !alert_output) else $error("alert high");
  a_alert_free: assert property (wr_c && !pwdata[9] |-> ##[1:3] alert_output) else $error("alert low");
  a_feat_read: assert property (psel && penable && !pwrite && paddr == SMBX_FEAT_OFF |-> prdata == 32'h1)
    else $error("feature bad");
  a_arb_irq: assert property (slave_arb_lost && !master_mode && ctrl_m[8] && mask_m[8] |-> ##[1:3] irq)
    else $error("no irq");
  a_irq_masked: assert property ((mask_m == '0) [*3] |-> !irq) else $error("masked irq");
  a_susp_rise: assert property ($rose(suspend_out) |-> master_mode && ctrl_m[11]) else $error("bad suspend");
  a_susp_off: assert property (!ctrl_m[10] [*3] |-> !suspend_out) else $error("suspend stuck");
  a_hold_slave: assert property ($fell(scl_oe_n) |-> !master_mode && (suspend_in || $past(suspend_in, 3) || ctrl_m[10]))
    else $error("bad hold");
  a_hold_end: assert property ((!suspend_in && !ctrl_m[10]) [*6] |-> scl_oe_n) else $error("hold stuck");
  a_scl_zero: assert property (scl_out == 1'b0) else $error("scl out high");
  c_hold: cover property (!scl_oe_n);
  c_irq: cover property ($rose(irq));
  c_susp: cover property ($rose(suspend_out));
  c_alert: cover property (!alert_output);
endmodule
bind smbx_top smbx_top_monitor smbx_top_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
  .master_mode(master_mode), .slave_arb_lost(slave_arb_lost), .alert_seen(alert_seen),
  .suspend_in(suspend_in), .suspend_out(suspend_out), .alert_output(alert_output), .irq(irq));
`default_nettype wire

//--- bench/smbx_top_test.sv
// Purpose: Self-checking bench for the bus extension block
// Assumes: APB master on pclk, one external bus master
// Notes: Small limits keep frames short
`timescale 1ns/1ps
`default_nettype none
module smbx_top_test;
  import smbx_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, master_mode, slave_arb_lost, alert_seen, suspend_in, go;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic pready, pslverr, scl_oe_n, suspend_out, alert_output, irq, busy;
  logic [15:0] stretch;
  wire scl, sda;
  int miscompares = 0;
  int checked = 0;
  int unsigned msk [5] = '{32'hF3F, 32'h3FFFFF, 32'h3FFFFF, 32'hFFFFF, 32'h1FFFFF};
  int unsigned mdl [5];
  smbx_top smbx_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
    .sda_in(sda), .scl_out(), .scl_oe_n(scl_oe_n), .master_mode(master_mode), .slave_arb_lost(slave_arb_lost),
    .alert_seen(alert_seen), .suspend_in(suspend_in), .suspend_out(suspend_out), .alert_output(alert_output),
    .irq(irq));
  smbx_bus_model smbx_bus_model_i (.go(go), .stretch(stretch), .scl_oe_n(scl_oe_n), .busy(busy), .scl(scl),
    .sda(sda));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic chk_pin(input logic g, input logic x);
    checked++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR t=%0t pin got %h exp %h", $time, g, x);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      results();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
  endtask
  task automatic frame(input logic [15:0] s);
    int n;
    @(posedge pclk);
    stretch <= s;
    go <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!(n > 2 && busy === 1'b0) && n < 5000);
    go <= 1'b0;
    if (n >= 5000) begin
      miscompares++;
      results();
    end
    repeat (6) @(posedge pclk);
  endtask
  initial begin
    logic [31:0] v;
    logic [31:0] q;
    logic e;
    seed = 32'h91BB;
    {psel, penable, pwrite, master_mode, slave_arb_lost, alert_seen, suspend_in, go} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stretch = 16'h0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 9; k++) rd(8'h1C + 8'(k * 4), (k == 6) ? 32'h1 : 32'h0);
    for (int k = 0; k < 5; k++) begin
      v = rnd();
      mdl[k] = v & msk[k];
      wr(8'h1C + 8'(k * 4), v);
      rd(8'h1C + 8'(k * 4), mdl[k]);
    end
    for (int k = 0; k < 5; k++) rd(8'h1C + 8'(k * 4), mdl[k]);
    apb(1'b1, 8'h30, 32'hFFFFFFFF, q, e);
    chk_pin(e, 1'b1);
    wr(SMBX_CTRL_OFF, 32'h200);
    repeat (3) @(posedge pclk);
    chk_pin(alert_output, 1'b0);
    wr(SMBX_CTRL_OFF, 32'h100);
    repeat (3) @(posedge pclk);
    chk_pin(alert_output, 1'b1);
    wr(SMBX_MASK_OFF, 32'h100);
    slave_arb_lost <= 1'b1;
    alert_seen <= 1'b1;
    @(posedge pclk);
    slave_arb_lost <= 1'b0;
    alert_seen <= 1'b0;
    rd(SMBX_STAT_OFF, 32'h100);
    chk_pin(irq, 1'b1);
    wr(SMBX_MASK_OFF, 32'h0);
    repeat (3) @(posedge pclk);
    chk_pin(irq, 1'b0);
    wr(SMBX_STAT_OFF, 32'hFFF);
    wr(SMBX_CTRL_OFF, 32'h038);
    alert_seen <= 1'b1;
    suspend_in <= 1'b1;
    @(posedge pclk);
    alert_seen <= 1'b0;
    repeat (6) @(posedge pclk);
    rd(SMBX_STAT_OFF, 32'h018);
    suspend_in <= 1'b0;
    repeat (6) @(posedge pclk);
    rd(SMBX_STAT_OFF, 32'h038);
    wr(SMBX_STAT_OFF, 32'hFFF);
    wr(SMBX_CTRL_OFF, 32'h0);
    suspend_in <= 1'b1;
    fork
      frame(16'h0);
      begin
        repeat (40) @(posedge pclk);
        chk_pin(scl_oe_n, 1'b0);
        suspend_in <= 1'b0;
      end
    join
    chk_pin(scl_oe_n, 1'b1);
    wr(SMBX_STAT_OFF, 32'hFFF);
    wr(SMBX_MAXT_OFF, 32'd30);
    wr(SMBX_MINT_OFF, 32'd0);
    wr(SMBX_MEXT_OFF, 32'd10);
    wr(SMBX_SEXT_OFF, 32'd20);
    wr(SMBX_CTRL_OFF, 32'h007);
    frame(16'd60);
    rd(SMBX_STAT_OFF, 32'h005);
    wr(SMBX_STAT_OFF, 32'hFFF);
    master_mode <= 1'b1;
    frame(16'h0);
    rd(SMBX_STAT_OFF, 32'h002);
    wr(SMBX_CTRL_OFF, 32'hC00);
    frame(16'h0);
    chk_pin(suspend_out, 1'b1);
    wr(SMBX_CTRL_OFF, 32'h0);
    repeat (3) @(posedge pclk);
    chk_pin(suspend_out, 1'b0);
    results();
  end
endmodule
`default_nettype wire

//--- design/smbx_pkg.sv
// Purpose: Constants for the bus management extension block
// Assumes: APB slave, 32-bit words, byte offsets
// Notes: Status, mask and feature registers sit after the printed ones
package smbx_pkg;
  localparam logic [7:0] SMBX_CTRL_OFF = 8'h1C;
  localparam logic [7:0] SMBX_MAXT_OFF = 8'h20;
  localparam logic [7:0] SMBX_MINT_OFF = 8'h24;
  localparam logic [7:0] SMBX_MEXT_OFF = 8'h28;
  localparam logic [7:0] SMBX_SEXT_OFF = 8'h2C;
  localparam logic [7:0] SMBX_FEAT_OFF = 8'h34;
  localparam logic [7:0] SMBX_STAT_OFF = 8'h38;
  localparam logic [7:0] SMBX_MASK_OFF = 8'h3C;
  localparam int SMBX_SUSOUT_BIT = 11;
  localparam int SMBX_SUSAFT_BIT = 10;
  localparam int SMBX_ALERT_BIT = 9;
  localparam int SMBX_SAL_BIT = 8;
  localparam int SMBX_RSM_BIT = 5;
  localparam int SMBX_SUS_BIT = 4;
  localparam int SMBX_ALEN_BIT = 3;
  localparam int SMBX_TOUT_BIT = 2;
  localparam int SMBX_MEXT_BIT = 1;
  localparam int SMBX_SEXT_BIT = 0;
  localparam int SMBX_CTRL_W = 12;
  localparam int SMBX_TMO_W = 22;
  localparam int SMBX_MEXT_W = 20;
  localparam int SMBX_SEXT_W = 21;
  localparam logic [SMBX_CTRL_W-1:0] SMBX_CTRL_MASK = 12'hF3F;
  localparam logic [SMBX_CTRL_W-1:0] SMBX_EV_MASK = 12'h33F;
  localparam logic [3:0] SMBX_ACK_CNT = 4'h8;
  localparam logic [SMBX_CTRL_W-1:0] SMBX_CTRL_RST = 12'h000;
  localparam logic [SMBX_TMO_W-1:0] SMBX_TMO_RST = 22'h000000;
  localparam logic [SMBX_MEXT_W-1:0] SMBX_MEXT_RST = 20'h00000;
  localparam logic [SMBX_SEXT_W-1:0] SMBX_SEXT_RST = 21'h000000;
  localparam logic SMBX_FEATURE_PRESENT = 1'b1;
  typedef enum logic [1:0] {
    SMBX_IDLE = 2'b00,
    SMBX_MSTR = 2'b01,
    SMBX_SLV = 2'b11
  } smbx_role_t;
endpackage

//--- design/smbx_sync.sv
// Purpose: Three flop synchroniser with edge outputs
// Assumes: Input from outside the pclk domain
// Notes: Edges taken from second and third flops only; reset level is the pin's idle level
`timescale 1ns/1ps
`default_nettype none
module smbx_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic din,
  output logic dout,
  output logic rise,
  output logic fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic s1_nxt;
  logic s2_nxt;
  logic s3_nxt;
  always_comb begin
    s1_nxt = din;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end
  assign dout = s2_r;
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;
endmodule
`default_nettype wire

//--- design/smbx_top.sv
// Purpose: Bus management extension of a two-wire controller
// Assumes: APB slave on pclk, SCL and SDA sampled from pins
// Notes: Start, stop and ack found from sampled pins
`timescale 1ns/1ps
`default_nettype none
module smbx_top
  import smbx_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic master_mode,
  input wire logic slave_arb_lost,
  input wire logic alert_seen,
  input wire logic suspend_in,
  output logic suspend_out,
  output logic alert_output,
  output logic irq
);
  logic scl_s;
  logic scl_rise;
  logic sda_s;
  logic sda_rise;
  logic sda_fall;
  logic susp_s;
  logic susp_rise;
  logic susp_fall;

  // Pin synchronisers
  smbx_sync u_scl (
    .pclk(pclk),
    .presetn(presetn),
    .din(scl_in),
    .dout(scl_s),
    .rise(scl_rise),
    .fall()
  );

  smbx_sync u_sda (
    .pclk(pclk),
    .presetn(presetn),
    .din(sda_in),
    .dout(sda_s),
    .rise(sda_rise),
    .fall(sda_fall)
  );

  // Suspend idles low
  smbx_sync #(
    .RST_VAL(1'b0)
  ) u_sus (
    .pclk(pclk),
    .presetn(presetn),
    .din(suspend_in),
    .dout(susp_s),
    .rise(susp_rise),
    .fall(susp_fall)
  );

  function automatic logic over_limit(input logic [SMBX_TMO_W-1:0] cnt, input logic [SMBX_TMO_W-1:0] lim);
    over_limit = (lim != SMBX_TMO_RST) && (cnt > lim);
  endfunction

  function automatic logic [SMBX_TMO_W-1:0] sat_inc(input logic [SMBX_TMO_W-1:0] cnt);
    sat_inc = (&cnt) ? cnt : cnt + {{(SMBX_TMO_W-1){1'b0}}, 1'b1};
  endfunction

  // Bus events
  logic start_ev;
  logic stop_ev;
  logic ack_ev;
  logic in_frame_r;
  logic in_frame_nxt;
  logic [3:0] bit_cnt_r;
  logic [3:0] bit_cnt_nxt;
  assign start_ev = sda_fall & scl_s;
  assign stop_ev = sda_rise & scl_s;
  assign ack_ev = scl_rise & (bit_cnt_r == SMBX_ACK_CNT) & ~sda_s;

  // Registers
  logic [SMBX_CTRL_W-1:0] ctrl_r;
  logic [SMBX_CTRL_W-1:0] ctrl_nxt;
  logic [SMBX_TMO_W-1:0] maxt_r;
  logic [SMBX_TMO_W-1:0] maxt_nxt;
  logic [SMBX_TMO_W-1:0] mint_r;
  logic [SMBX_TMO_W-1:0] mint_nxt;
  logic [SMBX_MEXT_W-1:0] mext_r;
  logic [SMBX_MEXT_W-1:0] mext_nxt;
  logic [SMBX_SEXT_W-1:0] sext_r;
  logic [SMBX_SEXT_W-1:0] sext_nxt;
  logic [SMBX_CTRL_W-1:0] stat_r;
  logic [SMBX_CTRL_W-1:0] stat_nxt;
  logic [SMBX_CTRL_W-1:0] mask_r;
  logic [SMBX_CTRL_W-1:0] mask_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  // Suspend and counters
  logic susp_pend_r;
  logic susp_pend_nxt;
  logic susp_drv_r;
  logic susp_drv_nxt;
  logic hold_r;
  logic hold_nxt;
  logic [SMBX_TMO_W-1:0] low_cnt_r;
  logic [SMBX_TMO_W-1:0] low_cnt_nxt;
  logic [SMBX_TMO_W-1:0] mcum_r;
  logic [SMBX_TMO_W-1:0] mcum_nxt;
  logic [SMBX_TMO_W-1:0] scum_r;
  logic [SMBX_TMO_W-1:0] scum_nxt;
  logic tout_hit_r;
  logic tout_hit_nxt;
  logic mext_hit_r;
  logic mext_hit_nxt;
  logic sext_hit_r;
  logic sext_hit_nxt;
  logic [SMBX_CTRL_W-1:0] ev;
  logic sus_active;

  assign addr_ok = (paddr == SMBX_CTRL_OFF) || (paddr == SMBX_MAXT_OFF) || (paddr == SMBX_MINT_OFF)
    || (paddr == SMBX_MEXT_OFF) || (paddr == SMBX_SEXT_OFF) || (paddr == SMBX_FEAT_OFF)
    || (paddr == SMBX_STAT_OFF) || (paddr == SMBX_MASK_OFF);
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign rd_en = psel & ~penable & ~pwrite;
  assign sus_active = susp_s | susp_drv_r;

  always_comb begin
    in_frame_nxt = in_frame_r;
    bit_cnt_nxt = bit_cnt_r;
    if (start_ev) begin
      in_frame_nxt = 1'b1;
      bit_cnt_nxt = 4'h0;
    end else if (stop_ev) begin
      in_frame_nxt = 1'b0;
      bit_cnt_nxt = 4'h0;
    end else if (scl_rise && in_frame_r) begin
      bit_cnt_nxt = (bit_cnt_r == SMBX_ACK_CNT) ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  always_comb begin
    susp_pend_nxt = susp_pend_r;
    susp_drv_nxt = susp_drv_r;
    hold_nxt = hold_r;
    if (ctrl_r[SMBX_SUSAFT_BIT] && !susp_drv_r) begin
      susp_pend_nxt = 1'b1;
    end
    if (susp_pend_r && stop_ev) begin
      susp_drv_nxt = 1'b1;
      susp_pend_nxt = 1'b0;
    end
    if (!ctrl_r[SMBX_SUSAFT_BIT]) begin
      susp_drv_nxt = 1'b0;
      susp_pend_nxt = 1'b0;
    end
    if (start_ev && sus_active && !master_mode) begin
      hold_nxt = 1'b1;
    end
    if (!sus_active || master_mode) begin
      hold_nxt = 1'b0;
    end
  end

  always_comb begin
    low_cnt_nxt = low_cnt_r;
    mcum_nxt = mcum_r;
    scum_nxt = scum_r;
    if (!scl_s) begin
      low_cnt_nxt = sat_inc(low_cnt_r);
    end else begin
      low_cnt_nxt = SMBX_TMO_RST;
    end
    if (in_frame_r && !scl_s && master_mode) begin
      mcum_nxt = sat_inc(mcum_r);
    end
    if (in_frame_r && !scl_s && !master_mode) begin
      scum_nxt = sat_inc(scum_r);
    end
    if (start_ev || ack_ev || stop_ev) begin
      mcum_nxt = SMBX_TMO_RST;
    end
    if (start_ev || stop_ev) begin
      scum_nxt = SMBX_TMO_RST;
    end
    tout_hit_nxt = over_limit(low_cnt_r, maxt_r) | over_limit(low_cnt_r, mint_r);
    mext_hit_nxt = over_limit(mcum_r, {2'b00, mext_r});
    sext_hit_nxt = over_limit(scum_r, {1'b0, sext_r});
  end

  always_comb begin
    ev = SMBX_CTRL_RST;
    ev[SMBX_SAL_BIT] = slave_arb_lost & ~master_mode;
    ev[SMBX_RSM_BIT] = susp_fall;
    ev[SMBX_SUS_BIT] = susp_rise;
    ev[SMBX_ALEN_BIT] = alert_seen;
    ev[SMBX_TOUT_BIT] = tout_hit_nxt & ~tout_hit_r;
    ev[SMBX_MEXT_BIT] = mext_hit_nxt & ~mext_hit_r;
    ev[SMBX_SEXT_BIT] = sext_hit_nxt & ~sext_hit_r;
    ev = ev & ctrl_r & SMBX_EV_MASK;
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    maxt_nxt = maxt_r;
    mint_nxt = mint_r;
    mext_nxt = mext_r;
    sext_nxt = sext_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    if (wr_en) begin
      unique case (paddr)
        SMBX_CTRL_OFF: begin
          ctrl_nxt = pwdata[SMBX_CTRL_W-1:0] & SMBX_CTRL_MASK;
        end
        SMBX_MAXT_OFF: begin
          maxt_nxt = pwdata[SMBX_TMO_W-1:0];
        end
        SMBX_MINT_OFF: begin
          mint_nxt = pwdata[SMBX_TMO_W-1:0];
        end
        SMBX_MEXT_OFF: begin
          mext_nxt = pwdata[SMBX_MEXT_W-1:0];
        end
        SMBX_SEXT_OFF: begin
          sext_nxt = pwdata[SMBX_SEXT_W-1:0];
        end
        SMBX_STAT_OFF: begin
          stat_nxt = stat_r & ~pwdata[SMBX_CTRL_W-1:0];
        end
        SMBX_MASK_OFF: begin
          mask_nxt = pwdata[SMBX_CTRL_W-1:0] & SMBX_CTRL_MASK;
        end
        default: begin
        end
      endcase
    end
    stat_nxt = stat_nxt | ev;
  end

  always_comb begin
    rdata_nxt = rdata_r;
    if (rd_en) begin
      rdata_nxt = 32'h00000000;
      unique case (paddr)
        SMBX_CTRL_OFF: rdata_nxt[SMBX_CTRL_W-1:0] = ctrl_r;
        SMBX_MAXT_OFF: rdata_nxt[SMBX_TMO_W-1:0] = maxt_r;
        SMBX_MINT_OFF: rdata_nxt[SMBX_TMO_W-1:0] = mint_r;
        SMBX_MEXT_OFF: rdata_nxt[SMBX_MEXT_W-1:0] = mext_r;
        SMBX_SEXT_OFF: rdata_nxt[SMBX_SEXT_W-1:0] = sext_r;
        SMBX_FEAT_OFF: rdata_nxt[0] = SMBX_FEATURE_PRESENT;
        SMBX_STAT_OFF: rdata_nxt[SMBX_CTRL_W-1:0] = stat_r;
        SMBX_MASK_OFF: rdata_nxt[SMBX_CTRL_W-1:0] = mask_r;
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame_r <= 1'b0;
      bit_cnt_r <= 4'h0;
      ctrl_r <= SMBX_CTRL_RST;
      maxt_r <= SMBX_TMO_RST;
      mint_r <= SMBX_TMO_RST;
      mext_r <= SMBX_MEXT_RST;
      sext_r <= SMBX_SEXT_RST;
      stat_r <= SMBX_CTRL_RST;
      mask_r <= SMBX_CTRL_RST;
      rdata_r <= 32'h00000000;
      susp_pend_r <= 1'b0;
      susp_drv_r <= 1'b0;
      hold_r <= 1'b0;
      low_cnt_r <= SMBX_TMO_RST;
      mcum_r <= SMBX_TMO_RST;
      scum_r <= SMBX_TMO_RST;
      tout_hit_r <= 1'b0;
      mext_hit_r <= 1'b0;
      sext_hit_r <= 1'b0;
    end else begin
      in_frame_r <= in_frame_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      ctrl_r <= ctrl_nxt;
      maxt_r <= maxt_nxt;
      mint_r <= mint_nxt;
      mext_r <= mext_nxt;
      sext_r <= sext_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
      susp_pend_r <= susp_pend_nxt;
      susp_drv_r <= susp_drv_nxt;
      hold_r <= hold_nxt;
      low_cnt_r <= low_cnt_nxt;
      mcum_r <= mcum_nxt;
      scum_r <= scum_nxt;
      tout_hit_r <= tout_hit_nxt;
      mext_hit_r <= mext_hit_nxt;
      sext_hit_r <= sext_hit_nxt;
    end
  end

  assign prdata = rdata_r;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign scl_out = 1'b0;
  assign scl_oe_n = ~hold_r;
  assign suspend_out = susp_drv_r & ctrl_r[SMBX_SUSOUT_BIT] & master_mode;
  assign alert_output = ~ctrl_r[SMBX_ALERT_BIT];
  assign irq = |(stat_r & mask_r);
endmodule
`default_nettype wire
